// ===== core/sbcomc_regs.vh
`ifndef SBCOMC_REGS_VH
`define SBCOMC_REGS_VH

// Core clock rate
`define SBCOMC_CLK_MHZ 25

// Reset pulse, normal-request timeout, watchdog and cyclic periods, in their own units
`define SBCOMC_RST_TIME_US 1000
`define SBCOMC_NREQ_TIME_MS 150
`define SBCOMC_WD_TIME_MS 150
`define SBCOMC_CYC_TIME_MS 50

// Cycle counts at the core clock, sized to the timer width (the on-time to its 4-bit counter) so nothing is cut silently
`define SBCOMC_RST_CYCLES 22'h0061a8
`define SBCOMC_NREQ_CYCLES 22'h393870
`define SBCOMC_WD_CYCLES 22'h393870
`define SBCOMC_CYC_CYCLES 22'h1312d0
`define SBCOMC_CYC_ON_CYCLES 4'h8

// Timer width
`define SBCOMC_TW 22

// Mode select field values
`define SBCOMC_SEL_NORMAL 2'h0
`define SBCOMC_SEL_STOP 2'h1
`define SBCOMC_SEL_SLEEP 2'h2

// Operating mode codes
`define SBCOMC_M_RESET 3'h0
`define SBCOMC_M_NREQ 3'h1
`define SBCOMC_M_NORMAL 3'h2
`define SBCOMC_M_SLEEP 3'h3
`define SBCOMC_M_STOP 3'h4

// Interrupt source bit positions
`define SBCOMC_INT_UV 0
`define SBCOMC_INT_OV 1
`define SBCOMC_INT_PREW 2
`define SBCOMC_INT_HSOT 3
`define SBCOMC_INT_BUS 4
`define SBCOMC_INT_WAKE 5
`define SBCOMC_NINT 6

// Wake source bit positions
`define SBCOMC_WK_INPUT 0
`define SBCOMC_WK_BUS 1
`define SBCOMC_WK_FORCED 2
`define SBCOMC_WK_CYCLIC 3

`endif

// ===== core/sbcomc_timer.v
`timescale 1ns/1ps
`include "sbcomc_regs.vh"

module sbcomc_timer (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  input wire ce,
  // Control
  input wire restart,
  input wire run,
  input wire [`SBCOMC_TW-1:0] limit,
  // Status
  output wire done
);
  reg [`SBCOMC_TW-1:0] count_r;

  assign done = (count_r == limit);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      count_r <= {`SBCOMC_TW{1'b0}};
    end else if (ce) begin
      if (restart) begin
        count_r <= {`SBCOMC_TW{1'b0}};
      end else if (run && !done) begin
        count_r <= count_r + 1'b1;
      end
    end
  end
endmodule

// ===== core/sbcomc_wdog.v
`timescale 1ns/1ps
`include "sbcomc_regs.vh"

module sbcomc_wdog (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  input wire ce,
  // Control
  input wire enable,
  input wire service,
  input wire [`SBCOMC_TW-1:0] period,
  // Status
  output reg fail_r
);
  reg [`SBCOMC_TW-1:0] count_r;
  wire [`SBCOMC_TW-1:0] half;
  wire windowOpen;

  assign half = {1'b0, period[`SBCOMC_TW-1:1]};
  assign windowOpen = (count_r >= half);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      count_r <= {`SBCOMC_TW{1'b0}};
      fail_r <= 1'b0;
    end else if (ce) begin
      fail_r <= 1'b0;
      if (!enable) begin
        count_r <= {`SBCOMC_TW{1'b0}};
      end else if (service) begin
        // Early service counts as a runaway, same as overflow
        fail_r <= !windowOpen;
        count_r <= {`SBCOMC_TW{1'b0}};
      end else if (count_r == period) begin
        fail_r <= 1'b1;
        count_r <= {`SBCOMC_TW{1'b0}};
      end else begin
        count_r <= count_r + 1'b1;
      end
    end
  end
endmodule

// ===== core/sbcomc_mode_ctrl.v
`timescale 1ns/1ps
`include "sbcomc_regs.vh"

module sbcomc_mode_ctrl #(
  parameter [`SBCOMC_TW-1:0] RST_CYCLES = `SBCOMC_RST_CYCLES,
  parameter [`SBCOMC_TW-1:0] NREQ_CYCLES = `SBCOMC_NREQ_CYCLES,
  parameter [`SBCOMC_TW-1:0] WD_CYCLES = `SBCOMC_WD_CYCLES,
  parameter [`SBCOMC_TW-1:0] CYC_CYCLES = `SBCOMC_CYC_CYCLES
) (
  // Clock, reset, enable
  input wire core_clk,
  input wire rst_n,
  input wire ce,
  // Controller commands
  input wire modeWrite,
  input wire [1:0] modeSel,
  input wire timingWrite,
  input wire isrRead,
  input wire busStatusRead,
  input wire regStatusRead,
  input wire [4:0] intMask,
  input wire lpCyclicEn,
  input wire lpForcedEn,
  input wire lpInputWakeEn,
  // Analog monitors
  input wire vddLow,
  input wire regOvertemp,
  input wire regPrewarn,
  input wire supUnder,
  input wire supOver,
  input wire hsOvertemp,
  // Bus transceiver
  input wire busOvertemp,
  input wire busTxStuck,
  input wire busRxShort,
  input wire busOvercurrent,
  input wire busWake,
  // Pins
  input wire wdCfgGnd,
  input wire wdCfgOpen,
  input wire wakeInput,
  input wire csRise,
  input wire rstPinIn,
  output wire rstPinOut,
  output wire rstPinOe,
  output wire irqN,
  // Power and drivers
  output wire regOn,
  output wire regLimited,
  output wire busRxOnly,
  output wire busDriverEn,
  output wire hsCycleOn,
  output wire lpOscOn,
  output wire ctrlActive,
  output wire wdActive,
  // Status
  output wire [2:0] opMode,
  output reg [5:0] intSrc_r,
  output reg [3:0] wakeSrc_r,
  output reg batteryFailFlag_r,
  output reg regOvertempFlag_r,
  output reg busOvercurrentFlag_r,
  output reg busFault_r,
  output reg wdOff_r,
  output reg wdCfgFault_r
);
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg extRst_r;
  reg extRst_nxt;
  reg timingSeen_r;
  reg irqLow_r;
  reg [4:0] lvlPrev_r;
  reg wakeRef_r;
  reg cycSample_r;
  reg [3:0] onCnt_r;
  reg [3:0] wakeEvt;
  wire inReset;
  wire inNreq;
  wire inNormal;
  wire lowPower;
  wire rstDone;
  wire nreqDone;
  wire lpDone;
  wire wdFail;
  wire modeSvc;
  wire busFaultNow;
  wire [4:0] lvlNow;
  wire [4:0] lvlRise;
  wire wakeAny;
  wire stopWakeIrq;
  wire intAllowed;
  wire [5:0] intEnMask;
  wire cycEnd;

  assign inReset = (state_r == `SBCOMC_M_RESET);
  assign inNreq = (state_r == `SBCOMC_M_NREQ);
  assign inNormal = (state_r == `SBCOMC_M_NORMAL);
  assign lowPower = (state_r == `SBCOMC_M_SLEEP) || (state_r == `SBCOMC_M_STOP);
  assign modeSvc = modeWrite && inNormal;

  // Reset hold timer restarts while a condition is present
  sbcomc_timer u_rst_tmr (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .restart(!inReset || vddLow),
    .run(inReset),
    .limit(RST_CYCLES),
    .done(rstDone)
  );

  sbcomc_timer u_nreq_tmr (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .restart(!inNreq),
    .run(inNreq),
    .limit(NREQ_CYCLES),
    .done(nreqDone)
  );

  // Low-power period timer, restarts each period
  sbcomc_timer u_lp_tmr (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .restart(!lowPower || lpDone),
    .run(lowPower && (lpCyclicEn || lpForcedEn)),
    .limit(CYC_CYCLES),
    .done(lpDone)
  );

  sbcomc_wdog u_wdog (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .enable(wdActive),
    .service(modeSvc),
    .period(WD_CYCLES),
    .fail_r(wdFail)
  );

  // Pin outputs
  assign rstPinOut = 1'b0;
  assign rstPinOe = inReset && !extRst_r;
  assign irqN = !irqLow_r;
  assign opMode = state_r;

  // Mode-dependent power and driver controls
  assign regOn = !regOvertempFlag_r && !(state_r == `SBCOMC_M_SLEEP);
  assign regLimited = (state_r == `SBCOMC_M_STOP);
  assign busRxOnly = inNreq || (state_r == `SBCOMC_M_STOP);
  assign busDriverEn = inNormal && !busFault_r;
  assign ctrlActive = inNormal || inNreq;
  assign wdActive = inNormal && !wdOff_r && !wdCfgFault_r;
  assign hsCycleOn = lowPower && lpCyclicEn && (onCnt_r != 4'h0);
  assign lpOscOn = lowPower && (lpCyclicEn || lpForcedEn);

  // Cyclic sample taken on the last cycle of the switch on-time
  assign cycEnd = (onCnt_r == 4'h1);

  always @* begin
    wakeEvt = 4'h0;
    if (lowPower) begin
      wakeEvt[`SBCOMC_WK_BUS] = busWake;
      if (lpCyclicEn) begin
        wakeEvt[`SBCOMC_WK_CYCLIC] = cycEnd && (wakeInput != cycSample_r);
      end else begin
        wakeEvt[`SBCOMC_WK_FORCED] = lpForcedEn && lpDone;
        wakeEvt[`SBCOMC_WK_INPUT] = lpInputWakeEn && (wakeInput != wakeRef_r);
      end
    end
  end

  assign wakeAny = |wakeEvt;
  assign stopWakeIrq = (state_r == `SBCOMC_M_STOP) && wakeAny;

  assign busFaultNow = busOvertemp || busTxStuck || busRxShort;
  assign lvlNow = {busFaultNow, hsOvertemp, regPrewarn, supOver, supUnder};
  assign lvlRise = lvlNow & ~lvlPrev_r;
  // Mask bit high enables; stop wake cannot be masked
  assign intEnMask = {1'b1, intMask};
  assign intAllowed = (inNormal || inNreq || (state_r == `SBCOMC_M_STOP)) && rstPinIn;

  // Mode transitions
  always @* begin
    state_nxt = state_r;
    extRst_nxt = extRst_r;
    case (state_r)
      `SBCOMC_M_RESET: begin
        // An external reset releases with no extra hold time
        if (extRst_r ? rstPinIn : rstDone) begin
          state_nxt = wdOff_r ? `SBCOMC_M_NORMAL : `SBCOMC_M_NREQ;
          extRst_nxt = 1'b0;
        end
      end
      `SBCOMC_M_NREQ: begin
        if (vddLow) begin
          state_nxt = `SBCOMC_M_RESET;
        end else if (!rstPinIn) begin
          state_nxt = `SBCOMC_M_RESET;
          extRst_nxt = 1'b1;
        end else if (modeWrite && modeSel == `SBCOMC_SEL_NORMAL && timingSeen_r) begin
          state_nxt = `SBCOMC_M_NORMAL;
        end else if (nreqDone) begin
          state_nxt = wdCfgFault_r ? `SBCOMC_M_NORMAL : `SBCOMC_M_RESET;
        end
      end
      `SBCOMC_M_NORMAL: begin
        if (vddLow || wdFail) begin
          state_nxt = `SBCOMC_M_RESET;
        end else if (!rstPinIn) begin
          state_nxt = `SBCOMC_M_RESET;
          extRst_nxt = 1'b1;
        end else if (modeWrite && modeSel == `SBCOMC_SEL_SLEEP) begin
          state_nxt = `SBCOMC_M_SLEEP;
        end else if (modeWrite && modeSel == `SBCOMC_SEL_STOP) begin
          state_nxt = `SBCOMC_M_STOP;
        end
      end
      `SBCOMC_M_SLEEP: begin
        if (wakeAny) begin
          state_nxt = `SBCOMC_M_RESET;
        end
      end
      `SBCOMC_M_STOP: begin
        if (vddLow) begin
          state_nxt = `SBCOMC_M_RESET;
        end else if (!rstPinIn) begin
          state_nxt = `SBCOMC_M_RESET;
          extRst_nxt = 1'b1;
        end else if (wakeAny || csRise) begin
          state_nxt = `SBCOMC_M_NREQ;
        end
      end
      default: begin
        state_nxt = `SBCOMC_M_RESET;
        extRst_nxt = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= `SBCOMC_M_RESET;
      extRst_r <= 1'b0;
      wdOff_r <= 1'b0;
      wdCfgFault_r <= 1'b0;
      timingSeen_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      extRst_r <= extRst_nxt;
      // Watchdog strap only sampled in reset mode
      if (inReset) begin
        wdOff_r <= wdCfgGnd;
        wdCfgFault_r <= !wdCfgGnd && wdCfgOpen;
      end
      if (!inNreq) begin
        timingSeen_r <= 1'b0;
      end else if (timingWrite) begin
        timingSeen_r <= 1'b1;
      end
    end
  end

  // Low-power wake sampling
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wakeRef_r <= 1'b0;
      cycSample_r <= 1'b0;
      onCnt_r <= 4'h0;
    end else if (ce) begin
      if (!lowPower) begin
        wakeRef_r <= wakeInput;
        cycSample_r <= wakeInput;
        onCnt_r <= 4'h0;
      end else if (lpCyclicEn) begin
        if (lpDone) begin
          onCnt_r <= `SBCOMC_CYC_ON_CYCLES;
        end else if (onCnt_r != 4'h0) begin
          onCnt_r <= onCnt_r - 4'h1;
        end
        if (cycEnd) begin
          cycSample_r <= wakeInput;
        end
      end
    end
  end

  // Sticky flags; a set in the same cycle as its read wins
  always @(posedge core_clk) begin
    if (!rst_n) begin
      batteryFailFlag_r <= 1'b1;
      regOvertempFlag_r <= 1'b0;
      busOvercurrentFlag_r <= 1'b0;
      busFault_r <= 1'b0;
    end else if (ce) begin
      if (regStatusRead) begin
        batteryFailFlag_r <= 1'b0;
      end
      if (regOvertemp) begin
        regOvertempFlag_r <= 1'b1;
      end else if (regStatusRead) begin
        regOvertempFlag_r <= 1'b0;
      end
      if (busOvercurrent) begin
        busOvercurrentFlag_r <= 1'b1;
      end else if (busStatusRead) begin
        busOvercurrentFlag_r <= 1'b0;
      end
      if (busFaultNow) begin
        busFault_r <= 1'b1;
      end else if (busStatusRead) begin
        busFault_r <= 1'b0;
      end
    end
  end

  // Interrupt and wake source capture
  always @(posedge core_clk) begin
    if (!rst_n) begin
      lvlPrev_r <= 5'h00;
      intSrc_r <= 6'h00;
      wakeSrc_r <= 4'h0;
      irqLow_r <= 1'b0;
    end else if (ce) begin
      lvlPrev_r <= lvlNow;
      // Wake sources survive the sleep reset so software can read them
      wakeSrc_r <= (isrRead ? 4'h0 : wakeSrc_r) | wakeEvt;
      if (intAllowed) begin
        // Only normal and normal-request report level sources
        intSrc_r <= (isrRead ? 6'h00 : intSrc_r)
          | ({stopWakeIrq, (inNormal || inNreq) ? lvlRise : 5'h00} & intEnMask);
      end else if (isrRead) begin
        intSrc_r <= 6'h00;
      end
      if (!intAllowed || isrRead) begin
        irqLow_r <= 1'b0;
      end else if (stopWakeIrq) begin
        irqLow_r <= 1'b1;
      end else if (wakeSrc_r == 4'h0 && (|intSrc_r)) begin
        irqLow_r <= 1'b1;
      end
    end
  end
endmodule

// ===== tb/sbcomc_mcu_model.sv
`timescale 1ns/1ps
`include "sbcomc_regs.vh"

module sbcomc_mcu_model (
  // Clock and device state
  input wire logic core_clk,
  input wire logic [2:0] opMode,
  input wire logic irqN,
  // Behaviour
  input wire logic enable,
  input wire logic [3:0] lag,
  // Commands
  output logic timingWrite,
  output logic modeWrite,
  output logic [1:0] modeSel,
  output logic isrRead
);
  logic [4:0] waitCnt;

  initial begin
    timingWrite = 1'b0;
    modeWrite = 1'b0;
    modeSel = 2'h3;
    isrRead = 1'b0;
    waitCnt = 5'h00;
  end

  // Timing write first, mode write after it; a slow lag stays well inside the timeout
  always @(posedge core_clk) begin
    timingWrite <= 1'b0;
    modeWrite <= 1'b0;
    isrRead <= 1'b0;
    if (!enable || opMode != `SBCOMC_M_NREQ) begin
      waitCnt <= 5'h00;
    end else begin
      waitCnt <= waitCnt + 5'h01;
      if (waitCnt == {1'b0, lag}) timingWrite <= 1'b1;
      if (waitCnt == {1'b0, lag} + 5'h01) begin
        modeWrite <= 1'b1;
        modeSel <= `SBCOMC_SEL_NORMAL;
      end
    end
    if (enable && !irqN && !isrRead) isrRead <= 1'b1;
  end
endmodule

// ===== tb/sbcomc_assertions.sv
`timescale 1ns/1ps
`include "sbcomc_regs.vh"

module sbcomc_checker #(
  parameter [`SBCOMC_TW-1:0] NREQ_CYCLES = 22'h00003c
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic modeWrite,
  input wire logic [1:0] modeSel,
  input wire logic timingWrite,
  input wire logic isrRead,
  input wire logic rstPinIn,
  input wire logic rstPinOe,
  input wire logic irqN,
  input wire logic regOn,
  input wire logic regLimited,
  input wire logic busRxOnly,
  input wire logic [2:0] opMode
);
  logic seenTime_r;
  logic [`SBCOMC_TW:0] nreqCnt_r;

  always @(posedge core_clk) begin
    if (!rst_n || opMode != `SBCOMC_M_NREQ) begin
      seenTime_r <= 1'b0;
      nreqCnt_r <= '0;
    end else if (ce) begin
      nreqCnt_r <= nreqCnt_r + 1'b1;
      if (timingWrite) seenTime_r <= 1'b1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_pin_released: assert property (opMode != `SBCOMC_M_RESET |-> !rstPinOe)
    else $error("reset pin pulled outside reset mode");
  a_nreq_power: assert property (opMode == `SBCOMC_M_NREQ |-> regOn && busRxOnly)
    else $error("normal-request without regulator or receive-only bus");
  a_sleep_reg_off: assert property (opMode == `SBCOMC_M_SLEEP |-> !regOn)
    else $error("regulator on in sleep");
  a_stop_limited: assert property (opMode == `SBCOMC_M_STOP |-> regOn && regLimited)
    else $error("stop without limited regulator");
  a_stop_by_cmd: assert property (
    (opMode == `SBCOMC_M_STOP && $past(opMode) != `SBCOMC_M_STOP)
    |-> $past(modeWrite && modeSel == `SBCOMC_SEL_STOP))
    else $error("stop entered without command");
  a_sleep_exit_reset: assert property (($past(opMode) == `SBCOMC_M_SLEEP &&
    opMode != `SBCOMC_M_SLEEP) |-> opMode == `SBCOMC_M_RESET)
    else $error("sleep left other than through reset");
  a_no_irq_sleep: assert property ((opMode == `SBCOMC_M_SLEEP &&
    $past(opMode) == `SBCOMC_M_SLEEP) |-> irqN)
    else $error("interrupt asserted in sleep");
  a_irq_ack_high: assert property ((isrRead && ce && !irqN) |=> irqN)
    else $error("interrupt pin not released after read");
  a_normal_entry: assert property ((opMode == `SBCOMC_M_NREQ && seenTime_r &&
    modeWrite && ce && modeSel == `SBCOMC_SEL_NORMAL && rstPinIn)
    |=> opMode == `SBCOMC_M_NORMAL)
    else $error("normal command not taken");
  a_nreq_bounded: assert property (nreqCnt_r <= NREQ_CYCLES + 2)
    else $error("normal-request outlasted its timeout");

  c_sleep: cover property (opMode == `SBCOMC_M_SLEEP);
  c_stop: cover property (opMode == `SBCOMC_M_STOP);
  c_irq: cover property (!irqN);
  c_ack: cover property (isrRead && !irqN);
endmodule

bind sbcomc_mode_ctrl sbcomc_checker #(.NREQ_CYCLES(NREQ_CYCLES)) u_sbcomc_checker (
  .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .modeWrite(modeWrite), .modeSel(modeSel),
  .timingWrite(timingWrite), .isrRead(isrRead), .rstPinIn(rstPinIn), .rstPinOe(rstPinOe),
  .irqN(irqN), .regOn(regOn), .regLimited(regLimited), .busRxOnly(busRxOnly), .opMode(opMode));

// ===== tb/tb.sv
`timescale 1ns/1ps
`include "sbcomc_regs.vh"

module tb;
  localparam [21:0] RST = 22'h000014, NREQ = 22'h00003c, WDC = 22'h000190;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg tMode = 1'b0, tTime = 1'b0, tIsr = 1'b0, mEn = 1'b0, mcuRst = 1'b0, busRd = 1'b0;
  reg regRd = 1'b0, cycEn = 1'b0, inWakeEn = 1'b0, vddLow = 1'b0, busOc = 1'b0;
  reg busWake = 1'b0, wdGnd = 1'b0, wdOpen = 1'b0, wakeIn = 1'b0, csRise = 1'b0;
  reg [1:0] tSel = 2'h3;
  reg [3:0] mLag = 4'h0;
  reg [5:0] mon = 6'h00;
  reg [4:0] intMask = 5'h1f;
  wire mMode, mTime, mIsr, rstPinOe, irqN, regOn, regLimited, busRxOnly, busDrvEn, lpOscOn;
  wire batF, regOtF, busOcF, hsOn, ctrlAct, wdAct, busFlt, wdOff, wdFlt;
  wire [1:0] mSel;
  wire [2:0] opMode;
  wire [3:0] wakeSrc;
  wire [5:0] intSrc;
  // The reset pin has a pull-up: high unless someone pulls it down
  wire rstPinIn = !(rstPinOe || mcuRst);
  integer cyc = 0, waited = 0, normT = 0, i, seed, bad_count = 0, checks_done = 0;

  always #20 core_clk = ~core_clk;

  sbcomc_mcu_model u_sbcomc_mcu_model (.core_clk(core_clk), .opMode(opMode), .irqN(irqN),
    .enable(mEn), .lag(mLag), .timingWrite(mTime), .modeWrite(mMode), .modeSel(mSel),
    .isrRead(mIsr));

  sbcomc_mode_ctrl #(.RST_CYCLES(RST), .NREQ_CYCLES(NREQ), .WD_CYCLES(WDC),
    .CYC_CYCLES(22'h00001e)) u_sbcomc_mode_ctrl (
    .core_clk(core_clk), .rst_n(rst_n), .ce(1'b1), .modeWrite(tMode | mMode),
    .modeSel(mMode ? mSel : tSel), .timingWrite(tTime | mTime), .isrRead(tIsr | mIsr),
    .busStatusRead(busRd), .regStatusRead(regRd), .intMask(intMask), .lpCyclicEn(cycEn),
    .lpForcedEn(1'b0), .lpInputWakeEn(inWakeEn), .vddLow(vddLow), .regOvertemp(mon[5]),
    .regPrewarn(mon[2]), .supUnder(mon[0]), .supOver(mon[1]), .hsOvertemp(mon[3]),
    .busOvertemp(mon[4]), .busTxStuck(1'b0), .busRxShort(1'b0), .busOvercurrent(busOc),
    .busWake(busWake), .wdCfgGnd(wdGnd), .wdCfgOpen(wdOpen), .wakeInput(wakeIn),
    .csRise(csRise), .rstPinIn(rstPinIn), .rstPinOut(), .rstPinOe(rstPinOe), .irqN(irqN),
    .regOn(regOn), .regLimited(regLimited), .busRxOnly(busRxOnly), .busDriverEn(busDrvEn),
    .hsCycleOn(hsOn), .lpOscOn(lpOscOn), .ctrlActive(ctrlAct), .wdActive(wdAct),
    .opMode(opMode), .intSrc_r(intSrc), .wakeSrc_r(wakeSrc), .batteryFailFlag_r(batF),
    .regOvertempFlag_r(regOtF), .busOvercurrentFlag_r(busOcF), .busFault_r(busFlt),
    .wdOff_r(wdOff), .wdCfgFault_r(wdFlt));

  // Mode reached by a low-power or normal command
  function [2:0] cmdMode(input [1:0] sel);
    cmdMode = (sel == `SBCOMC_SEL_STOP) ? `SBCOMC_M_STOP :
      (sel == `SBCOMC_SEL_SLEEP) ? `SBCOMC_M_SLEEP : `SBCOMC_M_NORMAL;
  endfunction

  task tick(input integer n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task chk(input [7:0] got, input [7:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task ok(input cond);
    chk({7'h00, cond}, 8'h01);
  endtask

  task waitMode(input [2:0] m);
    waited = 0;
    while (opMode !== m && waited < 2000) begin
      tick(1);
      waited = waited + 1;
    end
    chk({5'h00, opMode}, {5'h00, m});
  endtask

  task cmd(input [1:0] s);
    tMode <= 1'b1;
    tSel <= s;
    tick(1);
    tMode <= 1'b0;
    tick(1);
  endtask

  // Low-power commands wait for the open window so they cannot count as an early service
  task toNormal(input win);
    mLag <= 4'($urandom % 8);
    mEn <= 1'b1;
    waitMode(`SBCOMC_M_NORMAL);
    mEn <= 1'b0;
    normT = cyc;
    while (win && cyc - normT < WDC / 2 + 4) tick(1);
  endtask

  task extReset;
    mcuRst <= 1'b1;
    tick(3);
    chk({5'h00, opMode}, 8'h00);
    mcuRst <= 1'b0;
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      bad_count = bad_count + 1;
      complete_run;
    end
  end

  initial begin
    seed = $urandom(78);
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    chk({5'h00, opMode}, 8'h00);
    ok(batF === 1'b1 && rstPinOe === 1'b1);
    waitMode(`SBCOMC_M_NREQ);
    ok(waited >= RST && waited <= RST + 3);
    ok(regOn === 1'b1 && busRxOnly === 1'b1 && rstPinOe === 1'b0);
    $display("test powerup done");
    cmd(`SBCOMC_SEL_NORMAL);
    chk({5'h00, opMode}, 8'h01);
    waitMode(`SBCOMC_M_RESET);
    ok(waited >= NREQ - 4 && waited <= NREQ + 2);
    waitMode(`SBCOMC_M_NREQ);
    regRd <= 1'b1;
    tick(1);
    regRd <= 1'b0;
    tick(1);
    ok(batF === 1'b0);
    tTime <= 1'b1;
    tick(1);
    tTime <= 1'b0;
    cmd(`SBCOMC_SEL_NORMAL);
    chk({5'h00, opMode}, {5'h00, cmdMode(`SBCOMC_SEL_NORMAL)});
    ok(wdAct === 1'b1 && ctrlAct === 1'b1);
    normT = cyc;
    $display("test handover done");
    for (i = 0; i < 6; i = i + 1) begin
      intMask <= 5'($urandom);
      mon[i] <= 1'b1;
      tick(3);
      if (i < 5) ok(irqN === !intMask[i] && intSrc[i] === intMask[i]);
      else ok(regOtF === 1'b1);
      if (i == 4) ok(busDrvEn === 1'b0 && busFlt === 1'b1);
      mon[i] <= 1'b0;
      tick(2);
      if (i == 4) ok(busDrvEn === 1'b0);
      busRd <= (i == 4);
      // The regulator stays off until its over-temperature flag is read away
      regRd <= (i == 5);
      tIsr <= 1'b1;
      tick(1);
      tIsr <= 1'b0;
      busRd <= 1'b0;
      regRd <= 1'b0;
      tick(1);
      ok(irqN === 1'b1 && busDrvEn === 1'b1 && regOn === 1'b1);
    end
    busOc <= 1'b1;
    tick(2);
    ok(busDrvEn === 1'b1 && busOcF === 1'b1);
    busOc <= 1'b0;
    $display("test interrupts done");
    while (cyc - normT < WDC / 2 + 4) tick(1);
    inWakeEn <= 1'b1;
    cmd(`SBCOMC_SEL_STOP);
    chk({5'h00, opMode}, {5'h00, cmdMode(`SBCOMC_SEL_STOP)});
    wakeIn <= 1'b1;
    waitMode(`SBCOMC_M_NREQ);
    tick(2);
    ok(irqN === 1'b0);
    tIsr <= 1'b1;
    tick(1);
    tIsr <= 1'b0;
    tick(1);
    ok(irqN === 1'b1);
    toNormal(1'b1);
    cmd(`SBCOMC_SEL_STOP);
    csRise <= 1'b1;
    tick(1);
    csRise <= 1'b0;
    waitMode(`SBCOMC_M_NREQ);
    tick(2);
    ok(irqN === 1'b1);
    toNormal(1'b1);
    cycEn <= 1'b1;
    cmd(`SBCOMC_SEL_STOP);
    wakeIn <= 1'b0;
    tick(32);
    ok(hsOn === 1'b1 && lpOscOn === 1'b1);
    waitMode(`SBCOMC_M_NREQ);
    ok(irqN === 1'b0 && wakeSrc[`SBCOMC_WK_CYCLIC] === 1'b1);
    tIsr <= 1'b1;
    tick(1);
    tIsr <= 1'b0;
    tick(1);
    ok(irqN === 1'b1 && wakeSrc === 4'h0);
    $display("test stop done");
    toNormal(1'b1);
    cmd(`SBCOMC_SEL_SLEEP);
    chk({5'h00, opMode}, {5'h00, cmdMode(`SBCOMC_SEL_SLEEP)});
    ok(regOn === 1'b0 && lpOscOn === 1'b1 && ctrlAct === 1'b0);
    busWake <= 1'b1;
    tick(2);
    busWake <= 1'b0;
    cycEn <= 1'b0;
    waitMode(`SBCOMC_M_RESET);
    ok(batF === 1'b0 && wakeSrc[`SBCOMC_WK_BUS] === 1'b1);
    waitMode(`SBCOMC_M_NREQ);
    $display("test sleep done");
    toNormal(1'b0);
    cmd(2'h3);
    waitMode(`SBCOMC_M_RESET);
    ok(waited < 6);
    waitMode(`SBCOMC_M_NREQ);
    toNormal(1'b0);
    waitMode(`SBCOMC_M_RESET);
    ok(waited >= WDC - 4 && waited <= WDC + 4);
    $display("test watchdog done");
    waitMode(`SBCOMC_M_NREQ);
    toNormal(1'b0);
    vddLow <= 1'b1;
    tick(3);
    chk({5'h00, opMode}, 8'h00);
    tick(2 * RST);
    ok(rstPinOe === 1'b1);
    vddLow <= 1'b0;
    waitMode(`SBCOMC_M_NREQ);
    ok(waited >= RST && waited <= RST + 3);
    wdOpen <= 1'b1;
    extReset;
    waitMode(`SBCOMC_M_NREQ);
    waitMode(`SBCOMC_M_NORMAL);
    ok(waited >= NREQ - 2 && waited <= NREQ + 3);
    ok(wdFlt === 1'b1 && wdAct === 1'b0);
    wdOpen <= 1'b0;
    wdGnd <= 1'b1;
    extReset;
    waitMode(`SBCOMC_M_NORMAL);
    ok(waited <= 3);
    ok(wdOff === 1'b1 && wdAct === 1'b0);
    $display("test config pin done");
    complete_run;
  end
endmodule
